// >>> shared/stc_pkg.sv
`default_nettype none
package stc_pkg;
  localparam int CDB_LEN = 6;
  localparam int CDB_IDX_W = 3;
  localparam int BYTE_W = 8;
  localparam int OPC_W = 5;
  localparam int COUNT_W = 24;
  localparam int CMD_W = OPC_W + COUNT_W + BYTE_W;
  localparam int IN_SYNC_W = 5 + BYTE_W;

  // Command block byte positions and fields
  localparam int CDB_OPC_BYTE = 0;
  localparam int CDB_LUN_BYTE = 1;
  localparam int CDB_CNT_MSB_BYTE = 2;
  localparam int CDB_CNT_MID_BYTE = 3;
  localparam int CDB_CNT_LSB_BYTE = 4;
  localparam int CDB_CTRL_BYTE = 5;
  localparam int CLASS_MSB = 7;
  localparam int CLASS_LSB = 5;
  localparam int OPC_MSB = 4;
  localparam int LUN_MSB = 7;
  localparam int LUN_LSB = 5;

  // Opcodes that have a command behind them, one bit per opcode
  localparam logic [31:0] OPC_SUPPORTED = 32'h0EFF_056B;

  // Completion status byte
  localparam logic [7:0] STATUS_GOOD = 8'h00;
  localparam int STAT_CHECK_BIT = 1;
  localparam int STAT_BUSY_BIT = 3;
  localparam int STAT_RESV_BIT = 4;

  // Message codes
  localparam logic [7:0] MSG_COMPLETE = 8'h00;
  localparam logic [7:0] MSG_SAVE_PTR = 8'h02;
  localparam logic [7:0] MSG_RESTORE_PTR = 8'h03;
  localparam logic [7:0] MSG_DISCONNECT = 8'h04;
  localparam logic [7:0] MSG_INIT_ERROR = 8'h05;
  localparam logic [7:0] MSG_ABORT = 8'h06;
  localparam logic [7:0] MSG_REJECT = 8'h07;
  localparam logic [7:0] MSG_NOP = 8'h08;
  localparam logic [7:0] MSG_BUS_RESET = 8'h0C;
  localparam int IDENT_BIT = 7;
  localparam int IDENT_DISC_BIT = 6;
  localparam logic [7:0] IDENT_ZERO_MASK = 8'h38;
  localparam logic [7:0] IDENT_BASE = 8'h80;
  localparam int IDENT_LUN_MSB = 2;

  // Phase lines {msg, c/d, i/o}
  localparam logic [2:0] PH_NONE = 3'b000;
  localparam logic [2:0] PH_DATA_IN = 3'b001;
  localparam logic [2:0] PH_COMMAND = 3'b010;
  localparam logic [2:0] PH_STATUS = 3'b011;
  localparam logic [2:0] PH_MSG_OUT = 3'b110;
  localparam logic [2:0] PH_MSG_IN = 3'b111;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_CMD     = 4'h1,
    ST_EXEC    = 4'h2,
    ST_SAVE    = 4'h3,
    ST_DISC    = 4'h4,
    ST_SUSP    = 4'h5,
    ST_RESEL   = 4'h6,
    ST_IDENT   = 4'h7,
    ST_RESTORE = 4'h8,
    ST_STATUS  = 4'h9,
    ST_CMPL    = 4'hA,
    ST_MSGO    = 4'hB,
    ST_REJECT  = 4'hC
  } stc_state_type;
endpackage
`default_nettype wire

// >>> rtl/stc_buf2.sv
`timescale 1ns/1ps
`default_nettype none
module stc_buf2 #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input  wire logic             mclk,
  input  wire logic             srst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [CNT_W-1:0] FULL = CNT_W'(DEPTH);
  localparam logic [PTR_W-1:0] LAST = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PTR_W-1:0] wr_reg;
  logic [PTR_W-1:0] rd_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_reg != FULL);
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem_reg[rd_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge mclk)
  begin
    if (push)
    begin
      mem_reg[wr_reg] <= in_data;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_reg <= (wr_reg == LAST) ? '0 : wr_reg + 1'b1;
      end
      if (pop)
      begin
        rd_reg <= (rd_reg == LAST) ? '0 : rd_reg + 1'b1;
      end
      if (push && !pop)
      begin
        cnt_reg <= cnt_reg + 1'b1;
      end
      else if (pop && !push)
      begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> rtl/stc_target.sv
// Contract
// - Command arrives as six bytes in order
// - Opcode is low five bits, 00h-1Fh
// - Pass 24-bit block count, MSB first
// - Status byte ends every command or error
// - Buffered write errors reported next command
// - Good is 00h; bits 0,2,5,6,7 zero
// - Busy bit 3 while unit still busy
// - Check bit 1 on blocking error
// - Reservation conflict sets bits 4 and 3
// - Message 00h after status, then bus free
// - Send 02h before disconnecting
// - Send 03h so host restores pointers
// - Send 04h after 02h, then bus free
// - Messages 06h or 0Ch fully reset controller; the code clears all but the input synchronizer flops
// - Either side may reject with 07h
// - Identify 80h-FFh carries logical unit
// - Disconnect only if identify bit 6 set
// - Drive MSG, C/D, I/O for phase
// - Interlocked REQ/ACK per byte
// - Take all six bytes before error status
// - ATN leads into message out phase
`timescale 1ns/1ps
`default_nettype none
module stc_target
  import stc_pkg::*;
#(
  parameter logic [7:0] RESEL_ID_MASK = 8'h81
) (
  input  wire logic               mclk,
  input  wire logic               srst,
  input  wire logic               bus_rst_in,
  input  wire logic               bus_sel_in,
  input  wire logic               bus_bsy_in,
  input  wire logic               bus_atn_in,
  input  wire logic               bus_ack_in,
  input  wire logic [BYTE_W-1:0]  bus_data_in,
  output logic                    bus_bsy_out,
  output logic                    bus_sel_out,
  output logic                    bus_req_out,
  output logic                    bus_msg_out,
  output logic                    bus_cd_out,
  output logic                    bus_io_out,
  output logic [BYTE_W-1:0]       bus_data_out,
  output logic                    bus_data_oe,
  output logic                    cmd_valid,
  input  wire logic               cmd_ready,
  output logic [OPC_W-1:0]        cmd_opcode,
  output logic [COUNT_W-1:0]      cmd_count,
  output logic [BYTE_W-1:0]       cmd_control,
  input  wire logic               exec_done,
  input  wire logic               exec_check,
  input  wire logic               exec_conflict,
  input  wire logic               exec_disc_req,
  input  wire logic               deferred_err,
  input  wire logic               unit_busy,
  input  wire logic               resv_conflict,
  output logic                    disc_allowed,
  output logic                    connected
);
  logic [IN_SYNC_W-1:0] meta_reg;
  logic [IN_SYNC_W-1:0] sync_reg;
  logic                 rst_s;
  logic                 sel_s;
  logic                 bsy_s;
  logic                 atn_s;
  logic                 ack_s;
  logic [BYTE_W-1:0]    data_s;

  stc_state_type        state_reg;
  stc_state_type        state_next;
  stc_state_type        resume_reg;
  stc_state_type        resume_next;
  logic                 req_reg;
  logic                 acked_reg;
  logic                 byte_end;
  logic [CDB_IDX_W-1:0] cdb_idx_reg;
  logic [BYTE_W-1:0]    cdb_reg [CDB_LEN];
  logic [BYTE_W-1:0]    msgo_reg;
  logic [BYTE_W-1:0]    stat_reg;
  logic                 deferred_reg;
  logic                 done_pend_reg;
  logic                 done_check_reg;
  logic                 done_conf_reg;
  logic                 push_valid_reg;
  logic                 push_ready;
  logic                 cdb_last;
  logic                 cdb_bad;
  logic                 cmd_good;
  logic                 abort_now;
  logic                 clr;

  function automatic logic is_xfer(input stc_state_type s);
    case (s)
      ST_CMD, ST_SAVE, ST_DISC, ST_IDENT, ST_RESTORE,
      ST_STATUS, ST_CMPL, ST_MSGO, ST_REJECT: is_xfer = 1'b1;
      default:                                 is_xfer = 1'b0;
    endcase
  endfunction

  function automatic logic [2:0] phase_of(input stc_state_type s);
    case (s)
      ST_CMD:    phase_of = PH_COMMAND;
      ST_STATUS: phase_of = PH_STATUS;
      ST_MSGO:   phase_of = PH_MSG_OUT;
      ST_RESEL:  phase_of = PH_DATA_IN;
      ST_SAVE, ST_DISC, ST_IDENT, ST_RESTORE,
      ST_CMPL, ST_REJECT: phase_of = PH_MSG_IN;
      default:   phase_of = PH_NONE;
    endcase
  endfunction

  function automatic logic [BYTE_W-1:0] byte_of(input stc_state_type s,
                                                input logic [BYTE_W-1:0] st);
    case (s)
      ST_SAVE:    byte_of = MSG_SAVE_PTR;
      ST_DISC:    byte_of = MSG_DISCONNECT;
      ST_IDENT:   byte_of = IDENT_BASE;
      ST_RESTORE: byte_of = MSG_RESTORE_PTR;
      ST_STATUS:  byte_of = st;
      ST_CMPL:    byte_of = MSG_COMPLETE;
      ST_REJECT:  byte_of = MSG_REJECT;
      ST_RESEL:   byte_of = RESEL_ID_MASK;
      default:    byte_of = '0;
    endcase
  endfunction

  // Bus pins are asynchronous; data rides with ACK through the same flops
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
    end
    else
    begin
      meta_reg <= {bus_rst_in, bus_sel_in, bus_bsy_in, bus_atn_in,
                   bus_ack_in, bus_data_in};
      sync_reg <= meta_reg;
    end
  end

  assign {rst_s, sel_s, bsy_s, atn_s, ack_s, data_s} = sync_reg;

  // Data is sampled at ACK rise, but ACK passes the same two flops
  assign byte_end  = acked_reg & ~ack_s;
  assign cdb_last  = (cdb_idx_reg == CDB_IDX_W'(CDB_LEN - 1));
  assign cdb_bad   = (cdb_reg[CDB_OPC_BYTE][CLASS_MSB:CLASS_LSB] != '0)
                   | (cdb_reg[CDB_LUN_BYTE][LUN_MSB:LUN_LSB] != '0)
                   | ~OPC_SUPPORTED[cdb_reg[CDB_OPC_BYTE][OPC_MSB:0]];
  assign cmd_good  = ~cdb_bad & ~unit_busy & ~resv_conflict & ~deferred_reg;
  assign abort_now = (state_reg == ST_MSGO) & byte_end
                   & ((msgo_reg == MSG_ABORT) | (msgo_reg == MSG_BUS_RESET));
  // Bus reset or abort message acts like the local reset, except the input synchronizer flops are not cleared
  assign clr       = srst | rst_s | abort_now;

  always_comb
  begin
    state_next  = state_reg;
    resume_next = resume_reg;
    case (state_reg)
      ST_IDLE:
        if (sel_s && !bsy_s)
        begin
          state_next  = atn_s ? ST_MSGO : ST_CMD;
          resume_next = ST_CMD;
        end
      ST_CMD:
        if (byte_end)
        begin
          // Error found early still waits for all six bytes
          if (!cdb_last)
            resume_next = ST_CMD;
          else if (cmd_good)
            resume_next = ST_EXEC;
          else
            resume_next = ST_STATUS;
          state_next = atn_s ? ST_MSGO : resume_next;
        end
      ST_EXEC:
        if (push_valid_reg)
          state_next = ST_EXEC;
        else if (atn_s)
        begin
          state_next  = ST_MSGO;
          resume_next = ST_EXEC;
        end
        else if (done_pend_reg)
          state_next = ST_STATUS;
        else if (exec_disc_req && disc_allowed)
          state_next = ST_SAVE;
      ST_SAVE:
        if (byte_end)
          state_next = ST_DISC;
      ST_DISC:
        if (byte_end)
          state_next = ST_SUSP;
      ST_SUSP:
        if (done_pend_reg)
          state_next = ST_RESEL;
      ST_RESEL:
        if (bsy_s)
          state_next = ST_IDENT;
      ST_IDENT:
        if (byte_end)
          state_next = ST_RESTORE;
      ST_RESTORE:
        if (byte_end)
          state_next = ST_STATUS;
      ST_STATUS:
        if (byte_end)
          state_next = ST_CMPL;
      ST_CMPL:
        if (byte_end)
          state_next = ST_IDLE;
      ST_MSGO:
        if (byte_end)
        begin
          if (msgo_reg[IDENT_BIT]
              || (msgo_reg == MSG_INIT_ERROR)
              || (msgo_reg == MSG_REJECT)
              || (msgo_reg == MSG_NOP))
            state_next = resume_reg;
          else
            state_next = ST_REJECT;
        end
      ST_REJECT:
        if (byte_end)
          state_next = resume_reg;
      default:
        state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (clr)
    begin
      state_reg  <= ST_IDLE;
      resume_reg <= ST_IDLE;
    end
    else
    begin
      state_reg  <= state_next;
      resume_reg <= resume_next;
    end
  end

  // REQ rises only once ACK is seen low, a cycle after phase and data; status data from ST_CMD or ST_EXEC comes with REQ
  always_ff @(posedge mclk)
  begin
    if (clr || !is_xfer(state_reg) || byte_end)
    begin
      req_reg   <= 1'b0;
      acked_reg <= 1'b0;
    end
    else if (req_reg && ack_s)
    begin
      req_reg   <= 1'b0;
      acked_reg <= 1'b1;
    end
    else if (!req_reg && !acked_reg && !ack_s)
    begin
      req_reg <= 1'b1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (clr)
    begin
      cdb_idx_reg <= '0;
      msgo_reg    <= '0;
    end
    else
    begin
      if (req_reg && ack_s && state_reg == ST_CMD)
        cdb_reg[cdb_idx_reg] <= data_s;
      if (req_reg && ack_s && state_reg == ST_MSGO)
        msgo_reg <= data_s;
      if (state_reg == ST_IDLE)
        cdb_idx_reg <= '0;
      else if (state_reg == ST_CMD && byte_end && !cdb_last)
        cdb_idx_reg <= cdb_idx_reg + 1'b1;
    end
  end

  // Identify from the host sets the disconnect privilege
  always_ff @(posedge mclk)
  begin
    if (clr || state_reg == ST_IDLE)
      disc_allowed <= 1'b0;
    else if (state_reg == ST_MSGO && byte_end && msgo_reg[IDENT_BIT]
             && ((msgo_reg & IDENT_ZERO_MASK) == '0))
      disc_allowed <= msgo_reg[IDENT_DISC_BIT];
  end

  // Deferred error survives until a later command picks it up;
  // a new error in the pickup cycle wins
  always_ff @(posedge mclk)
  begin
    if (srst || rst_s || abort_now)
      deferred_reg <= 1'b0;
    else if (deferred_err)
      deferred_reg <= 1'b1;
    else if (state_reg == ST_CMD && byte_end && cdb_last && !cdb_bad
             && !unit_busy && !resv_conflict)
      deferred_reg <= 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (clr)
    begin
      done_pend_reg  <= 1'b0;
      done_check_reg <= 1'b0;
      done_conf_reg  <= 1'b0;
    end
    else if (exec_done)
    begin
      done_pend_reg  <= 1'b1;
      done_check_reg <= exec_check;
      done_conf_reg  <= exec_conflict;
    end
    else if (state_next == ST_STATUS || state_next == ST_RESEL)
      done_pend_reg <= 1'b0;
  end

  // Only bits 1, 3 and 4 can ever be set
  always_ff @(posedge mclk)
  begin
    if (clr)
      stat_reg <= STATUS_GOOD;
    else if (state_reg == ST_CMD && byte_end && cdb_last)
    begin
      stat_reg <= STATUS_GOOD;
      if (cdb_bad)
        stat_reg[STAT_CHECK_BIT] <= 1'b1;
      else if (unit_busy)
        stat_reg[STAT_BUSY_BIT] <= 1'b1;
      else if (resv_conflict)
      begin
        stat_reg[STAT_BUSY_BIT] <= 1'b1;
        stat_reg[STAT_RESV_BIT] <= 1'b1;
      end
      else if (deferred_reg)
        stat_reg[STAT_CHECK_BIT] <= 1'b1;
    end
    else if (done_pend_reg && state_next != state_reg
             && (state_next == ST_STATUS || state_next == ST_RESEL))
    begin
      stat_reg <= STATUS_GOOD;
      stat_reg[STAT_CHECK_BIT] <= done_check_reg;
      stat_reg[STAT_BUSY_BIT]  <= done_conf_reg;
      stat_reg[STAT_RESV_BIT]  <= done_conf_reg;
    end
  end

  // Block waits here while the executor stalls the buffer
  always_ff @(posedge mclk)
  begin
    if (clr)
      push_valid_reg <= 1'b0;
    else if (state_reg == ST_CMD && byte_end && cdb_last && cmd_good)
      push_valid_reg <= 1'b1;
    else if (push_ready)
      push_valid_reg <= 1'b0;
  end

  stc_buf2 #(
    .WIDTH (CMD_W),
    .DEPTH (2)
  ) u_cmd_buf (
    .mclk      (mclk),
    .srst      (clr),
    .in_valid  (push_valid_reg),
    .in_ready  (push_ready),
    .in_data   ({cdb_reg[CDB_OPC_BYTE][OPC_MSB:0],
                 cdb_reg[CDB_CNT_MSB_BYTE],
                 cdb_reg[CDB_CNT_MID_BYTE],
                 cdb_reg[CDB_CNT_LSB_BYTE],
                 cdb_reg[CDB_CTRL_BYTE]}),
    .out_valid (cmd_valid),
    .out_ready (cmd_ready),
    .out_data  ({cmd_opcode, cmd_count, cmd_control})
  );

  // Bus outputs follow the next state so phase leads REQ
  always_ff @(posedge mclk)
  begin
    if (clr)
    begin
      bus_bsy_out  <= 1'b0;
      bus_sel_out  <= 1'b0;
      bus_msg_out  <= 1'b0;
      bus_cd_out   <= 1'b0;
      bus_io_out   <= 1'b0;
      bus_data_out <= '0;
      bus_data_oe  <= 1'b0;
      connected    <= 1'b0;
    end
    else
    begin
      bus_bsy_out <= (state_next != ST_IDLE) && (state_next != ST_SUSP)
                     && (state_next != ST_RESEL);
      bus_sel_out <= (state_next == ST_RESEL);
      {bus_msg_out, bus_cd_out, bus_io_out} <= phase_of(state_next);
      bus_data_out <= byte_of(state_next, stat_reg);
      bus_data_oe  <= phase_of(state_next) == PH_DATA_IN
                      || phase_of(state_next) == PH_STATUS
                      || phase_of(state_next) == PH_MSG_IN;
      connected    <= (state_next != ST_IDLE) && (state_next != ST_SUSP);
    end
  end

  assign bus_req_out = req_reg;
endmodule
`default_nettype wire

// >>> sim/stc_host.sv
`timescale 1ns/1ps
`default_nettype none
module stc_host
  import stc_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              req,
  input  wire logic              bsy_t,
  input  wire logic              sel_t,
  input  wire logic [2:0]        ph,
  input  wire logic [BYTE_W-1:0] wdata,
  output logic                   sel,
  output logic                   bsy,
  output logic                   atn,
  output logic                   ack,
  output logic                   d_oe,
  output logic [BYTE_W-1:0]      d
);
  initial
  begin
    {sel, bsy, atn, ack, d_oe} = 5'h00;
    d = 8'h00;
  end

  function automatic logic pick(input int w);
    case (w)
      0: return req;
      1: return bsy_t;
      default: return sel_t;
    endcase
  endfunction

  task automatic wt(input int w, input logic lv, input int lim,
                    output bit ok);
    int n;
    n = 0;
    while (pick(w) !== lv && n < lim)
    begin
      @(negedge mclk);
      n++;
    end
    ok = pick(w) === lv;
  endtask

  task automatic select(input logic a, output bit ok);
    atn = a;
    sel = 1'b1;
    wt(1, 1'b1, 50, ok);
    sel = 1'b0;
  endtask

  // Random ACK delay: answers both promptly and slowly
  task automatic xfer(input logic [7:0] ob, output logic [7:0] ib,
                      output logic [2:0] p, output bit ok);
    bit k;
    wt(0, 1'b1, 200, ok);
    p = ph;
    ib = wdata;
    if (p == PH_MSG_OUT)
      atn = 1'b0;
    d = ob;
    d_oe = !p[0];
    repeat (1 + $urandom % 4) @(negedge mclk);
    ack = 1'b1;
    wt(0, 1'b0, 200, k);
    ack = 1'b0;
    d_oe = 1'b0;
    ok = ok && k;
  endtask

  task automatic resel(output logic [7:0] id, output bit ok);
    bit k;
    wt(2, 1'b1, 200, ok);
    id = wdata;
    bsy = 1'b1;
    wt(1, 1'b1, 50, k);
    ok = ok && k;
    wt(2, 1'b0, 50, k);
    bsy = 1'b0;
    ok = ok && k;
  endtask
endmodule
`default_nettype wire

// >>> sim/stc_target_sva.sv
`timescale 1ns/1ps
`default_nettype none
module stc_target_sva
  import stc_pkg::*;
(
  input wire logic              mclk,
  input wire logic              srst,
  input wire logic              bus_ack_in,
  input wire logic              bus_req_out,
  input wire logic              bus_bsy_out,
  input wire logic              bus_msg_out,
  input wire logic              bus_cd_out,
  input wire logic              bus_io_out,
  input wire logic [BYTE_W-1:0] bus_data_out,
  input wire logic              bus_data_oe,
  input wire logic              cmd_valid,
  input wire logic              cmd_ready,
  input wire logic [OPC_W-1:0]  cmd_opcode
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  wire logic [2:0] ph = {bus_msg_out, bus_cd_out, bus_io_out};

  sequence s_taken;
    bus_req_out && bus_ack_in;
  endsequence
  sequence s_req_up;
    !bus_req_out ##1 bus_req_out;
  endsequence
  sequence s_status_end;
    bus_req_out && ph == PH_STATUS ##1 !bus_req_out;
  endsequence
  sequence s_cmpl_req;
    bus_req_out && ph == PH_MSG_IN && bus_data_out == MSG_COMPLETE;
  endsequence

  a_req_drops: assert property (s_taken |-> ##[1:4] !bus_req_out)
    else $error("REQ held after ACK");
  a_req_rise: assert property (s_req_up |-> !bus_ack_in)
    else $error("REQ raised while ACK high");
  a_bsy_xfer: assert property (bus_req_out |-> bus_bsy_out)
    else $error("REQ without BSY");
  a_status_zero: assert property (
    bus_req_out && ph == PH_STATUS |-> (bus_data_out & 8'hE5) == 8'h00)
    else $error("reserved status bit set");
  a_in_drives: assert property (bus_req_out && bus_io_out |-> bus_data_oe)
    else $error("inbound byte not driven");
  a_phase_hold: assert property (
    bus_req_out ##1 bus_req_out |-> $stable({ph, bus_data_out}))
    else $error("phase or data moved during REQ");
  a_cmpl_follows: assert property (s_status_end |-> ##[1:40] s_cmpl_req)
    else $error("no completion message after status");
  a_cmd_hold: assert property (
    cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_opcode))
    else $error("command word dropped while stalled");
  a_reset_clear: assert property (disable iff (1'b0)
    srst |=> !bus_req_out && !bus_bsy_out && !cmd_valid)
    else $error("outputs active after reset");
endmodule

bind stc_target stc_target_sva chk_u (
  .mclk(mclk), .srst(srst), .bus_ack_in(bus_ack_in),
  .bus_req_out(bus_req_out), .bus_bsy_out(bus_bsy_out),
  .bus_msg_out(bus_msg_out), .bus_cd_out(bus_cd_out),
  .bus_io_out(bus_io_out), .bus_data_out(bus_data_out),
  .bus_data_oe(bus_data_oe), .cmd_valid(cmd_valid),
  .cmd_ready(cmd_ready), .cmd_opcode(cmd_opcode)
);
`default_nettype wire

// >>> sim/stc_target_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module stc_target_tb_top;
  import stc_pkg::*;
  // Arbitrary reselection ID pattern
  localparam logic [7:0] RID = 8'h5A;
  logic        mclk, srst, rst_b, sel_h, bsy_h, atn_h, ack_h, doe_h;
  logic [7:0]  d_h, d_w, dout, cctl;
  logic        bsy_t, sel_t, req, msg, cd, io, oe, cv, crdy;
  logic [4:0]  copc;
  logic [23:0] ccnt;
  logic        done, ck, cf, dreq, derr, ubusy, rconf, dall, conn;
  logic [7:0]  cb [6];
  logic [7:0]  ms [6] = '{8'h08, 8'h05, 8'h07, 8'h41, 8'h06, 8'h0C};
  logic [36:0] q [$];
  bit          dpend;
  int          failures = 0;
  int          tests_run = 0;

  // Released data lines settle to the deasserted level
  assign d_w = oe ? dout : (doe_h ? d_h : 8'h00);

  stc_target #(.RESEL_ID_MASK(RID)) dut_u (
    .mclk(mclk), .srst(srst), .bus_rst_in(rst_b), .bus_sel_in(sel_h),
    .bus_bsy_in(bsy_h), .bus_atn_in(atn_h), .bus_ack_in(ack_h),
    .bus_data_in(d_w), .bus_bsy_out(bsy_t), .bus_sel_out(sel_t),
    .bus_req_out(req), .bus_msg_out(msg), .bus_cd_out(cd),
    .bus_io_out(io), .bus_data_out(dout), .bus_data_oe(oe),
    .cmd_valid(cv), .cmd_ready(crdy), .cmd_opcode(copc),
    .cmd_count(ccnt), .cmd_control(cctl), .exec_done(done),
    .exec_check(ck), .exec_conflict(cf), .exec_disc_req(dreq),
    .deferred_err(derr), .unit_busy(ubusy), .resv_conflict(rconf),
    .disc_allowed(dall), .connected(conn)
  );

  stc_host host_u (
    .mclk(mclk), .req(req), .bsy_t(bsy_t), .sel_t(sel_t),
    .ph({msg, cd, io}), .wdata(d_w), .sel(sel_h), .bsy(bsy_h),
    .atn(atn_h), .ack(ack_h), .d_oe(doe_h), .d(d_h)
  );

  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic okay(input bit ok);
    if (!ok)
    begin
      failures++;
      $display("BAD t=%0t handshake timeout", $time);
      test_done;
    end
  endtask

  task automatic go(input logic a);
    bit ok;
    host_u.select(a, ok);
    okay(ok);
  endtask

  task automatic xb(input logic [7:0] ob, input logic [2:0] ep,
                    input logic [7:0] eb);
    logic [7:0] ib;
    logic [2:0] p;
    bit         ok;
    host_u.xfer(ob, ib, p, ok);
    okay(ok);
    chk(p, ep);
    chk(conn, 1'b1);
    if (ep[0])
      chk(ib, eb);
  endtask

  task automatic free_chk;
    bit ok;
    host_u.wt(1, 1'b0, 10, ok);
    okay(ok);
    chk({req, cv, conn}, 3'b000);
    repeat (4) @(negedge mclk);
  endtask

  task automatic exec(input int dq, output logic [7:0] st);
    int         n;
    logic [1:0] r;
    logic [36:0] e;
    bit         ok;
    q.push_back({cb[0][4:0], cb[2], cb[3], cb[4], cb[5]});
    n = 0;
    while (cv !== 1'b1 && n < 100)
    begin
      @(negedge mclk);
      n++;
    end
    okay(cv === 1'b1);
    // Stall the consumer 0 to 4 cycles, so the buffer may have to hold the word
    repeat ($urandom % 5) @(negedge mclk);
    e = q.pop_front();
    chk({copc, ccnt, cctl}, e);
    crdy = 1'b1;
    @(negedge mclk);
    crdy = 1'b0;
    dreq = dq != 0;
    if (dq == 2)
    begin
      xb(8'h00, PH_MSG_IN, MSG_SAVE_PTR);
      xb(8'h00, PH_MSG_IN, MSG_DISCONNECT);
      free_chk;
    end
    else
      repeat (20) @(negedge mclk);
    dreq = 1'b0;
    r = 2'($urandom % 3);
    {ck, cf, done} = {r == 2'd1, r == 2'd2, 1'b1};
    @(negedge mclk);
    {ck, cf, done} = 3'b000;
    st = r == 2'd1 ? 8'h02 : (r == 2'd2 ? 8'h18 : STATUS_GOOD);
    if (dq == 2)
    begin
      host_u.resel(e[7:0], ok);
      okay(ok);
      chk(e[7:0], RID);
      xb(8'h00, PH_MSG_IN, IDENT_BASE);
      xb(8'h00, PH_MSG_IN, MSG_RESTORE_PTR);
    end
  endtask

  task automatic run_cmd(input logic [7:0] m, input int dq);
    logic [7:0] st;
    st = STATUS_GOOD;
    for (int i = 0; i < 6; i++)
    begin
      if (i == 2 && m != 8'h00)
      begin
        // ATN lands with the ACK release, so byte 1 ends into message out
        host_u.atn = 1'b1;
        xb(m, PH_MSG_OUT, 8'h00);
        if (m == MSG_ABORT || m == MSG_BUS_RESET)
        begin
          free_chk;
          return;
        end
        if (!(m inside {MSG_INIT_ERROR, MSG_REJECT, MSG_NOP}))
          xb(8'h00, PH_MSG_IN, MSG_REJECT);
      end
      xb(cb[i], PH_COMMAND, 8'h00);
    end
    if (cb[0][7:5] != 3'h0 || cb[1][7:5] != 3'h0 ||
        !OPC_SUPPORTED[cb[0][4:0]])
      st = 8'h02;
    else if (ubusy)
      st = 8'h08;
    else if (rconf)
      st = 8'h18;
    else if (dpend)
    begin
      st = 8'h02;
      dpend = 1'b0;
    end
    else
      exec(dq, st);
    xb(8'h00, PH_STATUS, st);
    xb(8'h00, PH_MSG_IN, MSG_COMPLETE);
    free_chk;
  endtask

  initial
  begin
    srst = 1'b1;
    {rst_b, crdy, done, ck, cf, dreq, derr, ubusy, rconf} = 9'h000;
    void'($urandom(32'h775f));
    repeat (8) @(negedge mclk);
    srst = 1'b0;
    repeat (3) @(negedge mclk);
    for (int k = 0; k < 16; k++)
    begin
      cb[0] = {($urandom % 6 == 0) ? 3'($urandom % 7 + 1) : 3'h0,
               5'($urandom)};
      cb[1] = {($urandom % 6 == 0) ? 3'h2 : 3'h0, 5'($urandom)};
      for (int j = 2; j < 6; j++)
        cb[j] = 8'($urandom);
      ubusy = ($urandom % 5) == 0;
      rconf = ($urandom % 5) == 0;
      go(1'b0);
      run_cmd(8'h00, 0);
    end
    {ubusy, rconf} = 2'b00;
    cb = '{default: 8'h00};
    $display("end random commands");
    derr = 1'b1;
    @(negedge mclk);
    derr = 1'b0;
    dpend = 1'b1;
    repeat (2)
    begin
      go(1'b0);
      run_cmd(8'h00, 0);
    end
    $display("end deferred error");
    go(1'b0);
    xb(cb[0], PH_COMMAND, 8'h00);
    rst_b = 1'b1;
    repeat (6) @(negedge mclk);
    chk({bsy_t, req}, 2'b00);
    rst_b = 1'b0;
    repeat (4) @(negedge mclk);
    foreach (ms[i])
    begin
      go(1'b0);
      run_cmd(ms[i], 0);
    end
    $display("end messages");
    cb[0] = 8'h01;
    for (int i = 0; i < 2; i++)
    begin
      go(1'b1);
      xb(i ? 8'h80 : 8'hC0, PH_MSG_OUT, 8'h00);
      // Privilege updates only once the ACK release has been synced
      repeat (4) @(negedge mclk);
      chk(dall, !i);
      run_cmd(8'h00, i ? 1 : 2);
    end
    $display("end disconnect");
    test_done;
  end
endmodule
`default_nettype wire
